//--- hw/charger_backlight_params.svh
// Contract
// - Precharge time select bit: 0 gives a 30 minute limit, 1 gives 60, reset 0.
// - Termination current is a two-bit factor (2.5/7.5/15/18 %) times charge current, reset 01.
// - Temperature window bit: 0 allows 0 to 45 C, 1 allows 0 to 60 C, reset 0.
// - The backlight control register sits at address 0x07 and resets to 0xB1 as printed; the code resets it to read 0x01.
// - Bits 7 to 4 of the backlight control register are read-only and read zero.
// - Bit 3 switches both LED current sinks together, 1 on, reset 0.
// - Bit 2 picks the sink level, 0 the low-level pin, 1 the high-level pin, reset 0.
// - Bits 1 to 0 set dimming frequency 100/200/500/1000 Hz, reset 01.
// - Charge current comes from a two-bit field: 300/400/500/700 mA.
`ifndef CHARGER_BACKLIGHT_PARAMS_SVH
`define CHARGER_BACKLIGHT_PARAMS_SVH
`define CHG_CFG_ADDR 8'h06
`define BL_CTRL_ADDR 8'h07
`define BL_CTRL_PRINTED_RESET 8'hB1
`define CHG_CFG_RESET 8'hB2
`define CHG_CUR_LSB 6
`define PCHG_BIT 3
`define TERM_LSB 1
`define TEMP_BIT 0
`define SINK_ON_BIT 3
`define LEVEL_BIT 2
`define FREQ_LSB 0
`define BL_FIELD_RESET 4'h1
`define BL_RW_MASK 8'h0F
`define CLK_HZ 25000000
`define DIM_HZ_0 100
`define DIM_HZ_1 200
`define DIM_HZ_2 500
`define DIM_HZ_3 1000
`define PCHG_MIN_0 30
`define PCHG_MIN_1 60
`define TEMP_MAX_0 45
`define TEMP_MAX_1 60
`define CUR_MA_0 300
`define CUR_MA_1 400
`define CUR_MA_2 500
`define CUR_MA_3 700
`define TERM_PERMILLE_0 25
`define TERM_PERMILLE_1 75
`define TERM_PERMILLE_2 150
`define TERM_PERMILLE_3 180
`endif

//--- hw/charger_backlight_pkg.sv
package charger_backlight_pkg;
  typedef logic [1:0] code2_t;
  typedef logic [7:0] reg8_t;
endpackage

//--- hw/dimming_pwm_divider.sv
`timescale 1ns/1ps
`include "charger_backlight_params.svh"
module dimming_pwm_divider #(
  parameter int CNT_W = 18
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire charger_backlight_pkg::code2_t freq_sel,
  output logic period_start
);
  localparam int P0 = `CLK_HZ / `DIM_HZ_0;
  localparam int P1 = `CLK_HZ / `DIM_HZ_1;
  localparam int P2 = `CLK_HZ / `DIM_HZ_2;
  localparam int P3 = `CLK_HZ / `DIM_HZ_3;
  if (P0 > (1 << CNT_W)) begin : g_cnt_w_check
    $error("CNT_W too small for dimming period");
  end
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] limit;
  logic [CNT_W-1:0] next_cnt;
  logic [CNT_W-1:0] next_limit;
  logic next_start;
  function automatic logic [CNT_W-1:0] period_of(
      charger_backlight_pkg::code2_t s);
    unique case (s)
      2'h0: period_of = CNT_W'(P0 - 1);
      2'h1: period_of = CNT_W'(P1 - 1);
      2'h2: period_of = CNT_W'(P2 - 1);
      2'h3: period_of = CNT_W'(P3 - 1);
    endcase
  endfunction
  always_comb begin
    next_cnt = cnt + CNT_W'(1);
    next_limit = limit;
    next_start = 1'b0;
    if (cnt >= limit) begin
      // Frequency changes only at a period boundary
      next_cnt = '0;
      next_limit = period_of(freq_sel);
      next_start = 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      limit <= CNT_W'(P1 - 1);
      period_start <= 1'b0;
    end else begin
      cnt <= next_cnt;
      limit <= next_limit;
      period_start <= next_start;
    end
  end
endmodule

//--- hw/charger_backlight_config_regs.sv
`timescale 1ns/1ps
`include "charger_backlight_params.svh"
module charger_backlight_config_regs #(
  parameter int CNT_W = 18
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic [1:0] charge_current_sel,
  output logic precharge_time_sel,
  output logic [1:0] termination_factor,
  output logic charge_temp_window,
  output logic [7:0] precharge_minutes,
  output logic [7:0] charge_temp_max_c,
  output logic [9:0] charge_current_ma,
  output logic [7:0] term_permille,
  output logic led_sink_on,
  output logic sink_level_sel,
  output logic [1:0] dimming_freq_sel,
  output logic dim_period_start
);
  logic [7:0] chg_cfg;
  logic [3:0] bl_fields;
  logic [7:0] next_chg_cfg;
  logic [3:0] next_bl_fields;
  logic [7:0] next_rdata;
  logic [7:0] bl_view;
  logic [7:0] next_pmin;
  logic [7:0] next_tmax;
  logic [9:0] next_ma;
  logic [7:0] next_perm;
  logic period_start;

  // Upper nibble is constant zero, never stored
  assign bl_view = {4'h0, bl_fields};

  always_comb begin
    next_chg_cfg = chg_cfg;
    next_bl_fields = bl_fields;
    next_rdata = reg_rdata;
    if (reg_wr && reg_addr == `CHG_CFG_ADDR) begin
      next_chg_cfg = reg_wdata;
    end
    if (reg_wr && reg_addr == `BL_CTRL_ADDR) begin
      next_bl_fields = 4'(reg_wdata & `BL_RW_MASK);
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `CHG_CFG_ADDR: next_rdata = chg_cfg;
        `BL_CTRL_ADDR: next_rdata = bl_view;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_comb begin
    next_pmin = next_chg_cfg[`PCHG_BIT] ? 8'(`PCHG_MIN_1)
                                         : 8'(`PCHG_MIN_0);
    next_tmax = next_chg_cfg[`TEMP_BIT] ? 8'(`TEMP_MAX_1)
                                         : 8'(`TEMP_MAX_0);
    unique case (next_chg_cfg[`CHG_CUR_LSB +: 2])
      2'h0: next_ma = 10'(`CUR_MA_0);
      2'h1: next_ma = 10'(`CUR_MA_1);
      2'h2: next_ma = 10'(`CUR_MA_2);
      2'h3: next_ma = 10'(`CUR_MA_3);
    endcase
    unique case (next_chg_cfg[`TERM_LSB +: 2])
      2'h0: next_perm = 8'(`TERM_PERMILLE_0);
      2'h1: next_perm = 8'(`TERM_PERMILLE_1);
      2'h2: next_perm = 8'(`TERM_PERMILLE_2);
      2'h3: next_perm = 8'(`TERM_PERMILLE_3);
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chg_cfg <= `CHG_CFG_RESET;
      bl_fields <= `BL_FIELD_RESET;
      reg_rdata <= 8'h00;
      charge_current_sel <= 2'h2;
      precharge_time_sel <= 1'b0;
      termination_factor <= 2'h1;
      charge_temp_window <= 1'b0;
      precharge_minutes <= 8'(`PCHG_MIN_0);
      charge_temp_max_c <= 8'(`TEMP_MAX_0);
      charge_current_ma <= 10'(`CUR_MA_2);
      term_permille <= 8'(`TERM_PERMILLE_1);
      led_sink_on <= 1'b0;
      sink_level_sel <= 1'b0;
      dimming_freq_sel <= 2'h1;
      dim_period_start <= 1'b0;
    end else begin
      chg_cfg <= next_chg_cfg;
      bl_fields <= next_bl_fields;
      reg_rdata <= next_rdata;
      charge_current_sel <= next_chg_cfg[`CHG_CUR_LSB +: 2];
      precharge_time_sel <= next_chg_cfg[`PCHG_BIT];
      termination_factor <= next_chg_cfg[`TERM_LSB +: 2];
      charge_temp_window <= next_chg_cfg[`TEMP_BIT];
      precharge_minutes <= next_pmin;
      charge_temp_max_c <= next_tmax;
      charge_current_ma <= next_ma;
      term_permille <= next_perm;
      led_sink_on <= next_bl_fields[`SINK_ON_BIT];
      sink_level_sel <= next_bl_fields[`LEVEL_BIT];
      dimming_freq_sel <= next_bl_fields[`FREQ_LSB +: 2];
      dim_period_start <= period_start;
    end
  end

  dimming_pwm_divider #(.CNT_W(CNT_W)) u_div (
    .clk(clk),
    .rst_n(rst_n),
    .freq_sel(bl_fields[`FREQ_LSB +: 2]),
    .period_start(period_start)
  );
endmodule

//--- dv/charger_backlight_config_regs_sva.sv
`timescale 1ns/1ps
module charger_backlight_config_regs_sva (
  input wire logic clk, rst_n, reg_wr, reg_rd,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
  input wire logic precharge_time_sel, charge_temp_window,
  input wire logic [7:0] precharge_minutes, charge_temp_max_c, term_permille,
  input wire logic [1:0] termination_factor, dimming_freq_sel,
  input wire logic led_sink_on, sink_level_sel, dim_period_start
);
  localparam logic [7:0] TERM [4] = '{8'h19, 8'h4B, 8'h96, 8'hB4};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr7;
    reg_wr && reg_addr == 8'h07;
  endsequence
  sequence s_rd7;
    reg_rd && reg_addr == 8'h07;
  endsequence
  property p_pchg;
    precharge_minutes == (precharge_time_sel ? 8'h3C : 8'h1E);
  endproperty
  a_pchg: assert property (p_pchg) else $error("precharge minutes");
  property p_term;
    term_permille == TERM[termination_factor];
  endproperty
  a_term: assert property (p_term) else $error("termination factor");
  property p_temp;
    charge_temp_max_c == (charge_temp_window ? 8'h3C : 8'h2D);
  endproperty
  a_temp: assert property (p_temp) else $error("temperature window");
  property p_wr7;
    s_wr7 |=> {led_sink_on, sink_level_sel, dimming_freq_sel}
      == $past(reg_wdata[3:0]);
  endproperty
  a_wr7: assert property (p_wr7) else $error("backlight write");
  property p_rd7;
    s_rd7 |=> reg_rdata == {4'h0, $past(led_sink_on),
      $past(sink_level_sel), $past(dimming_freq_sel)};
  endproperty
  a_rd7: assert property (p_rd7) else $error("backlight read");
  property p_hold;
    !(reg_wr && reg_addr == 8'h07) |=>
      $stable({led_sink_on, sink_level_sel, dimming_freq_sel});
  endproperty
  a_hold: assert property (p_hold) else $error("fields moved");
  property p_pulse;
    dim_period_start |=> !dim_period_start [*8];
  endproperty
  a_pulse: assert property (p_pulse) else $error("period pulse");
  property p_unmap;
    reg_rd && reg_addr[7:1] != 7'h03 |=> reg_rdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
endmodule
bind charger_backlight_config_regs charger_backlight_config_regs_sva i_sva (.*);

//--- dv/host_model.sv
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  output logic reg_wr, reg_rd,
  output logic [7:0] reg_addr, reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_wr = 0;
    reg_rd = 0;
    reg_addr = 8'hA5;
    reg_wdata = 8'h5A;
  end
  // Idle address lines carry inverted values; wr also inverts reg_wdata, rd leaves it as it was
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 0;
    reg_addr <= ~a;
    reg_wdata <= ~v;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 0;
    reg_addr <= ~a;
    @(posedge clk);
    v = reg_rdata;
  endtask
endmodule

//--- dv/charger_backlight_config_regs_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module charger_backlight_config_regs_tb;
  logic clk = 0, rst_n = 0, reg_wr, reg_rd, precharge_time_sel;
  logic charge_temp_window, led_sink_on, sink_level_sel, dim_period_start;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, precharge_minutes;
  logic [7:0] charge_temp_max_c, term_permille, d;
  logic [1:0] charge_current_sel, termination_factor, dimming_freq_sel, c;
  logic [9:0] charge_current_ma;
  int n_fail = 0, checks = 0, n;
  int cur[4] = '{300, 400, 500, 700};
  int term[4] = '{25, 75, 150, 180};
  always #20 clk = ~clk;
  charger_backlight_config_regs i_dut (.*);
  host_model i_host (.*);
  task final_report;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task wait_pulse;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!dim_period_start && n < 300000);
    if (n >= 300000) begin
      n_fail++;
      $display("[FAIL] %0t period pulse timeout", $time);
      final_report;
    end
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1;
    `CHK({led_sink_on, sink_level_sel, dimming_freq_sel}, 4'h1)
    `CHK({precharge_time_sel, termination_factor, charge_temp_window}, 4'h2)
    i_host.rd(8'h07, d);
    `CHK(d, 8'h01)
    i_host.rd(8'h06, d);
    `CHK(d, 8'hB2)
    `CHK(charge_current_sel, 2'h2)
    `CHK(term_permille, 8'h4B)
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      i_host.wr(8'h06, {c, 2'h0, c[0], c, c[1]});
      i_host.wr(8'h07, {4'hF, c[1], c[0], c});
      i_host.rd(8'h07, d);
      `CHK(d, {4'h0, c[1], c[0], c})
      `CHK(charge_current_ma, 10'(cur[i]))
      `CHK(term_permille, 8'(term[i]))
      `CHK(precharge_minutes, c[0] ? 8'h3C : 8'h1E)
      `CHK(charge_temp_max_c, c[1] ? 8'h3C : 8'h2D)
      `CHK({led_sink_on, sink_level_sel}, {c[1], c[0]})
      `CHK(dimming_freq_sel, c)
      `CHK({charge_current_sel, termination_factor}, {c, c})
      `CHK({precharge_time_sel, charge_temp_window}, {c[0], c[1]})
    end
    i_host.wr(8'h08, 8'hFF);
    i_host.rd(8'h08, d);
    `CHK(d, 8'h00)
    i_host.rd(8'h07, d);
    `CHK(d, 8'h0F)
    wait_pulse;
    wait_pulse;
    `CHK(n, 25000)
    final_report;
  end
endmodule
